// >>> src/rwic_ctrl.v
`timescale 1ns/1ns
`include "rwic_defines.vh"

// Behaviour
// R1: every reset loads pc from vector bytes, high byte at lower address
// R2: reset forces the stack pointer to its fixed initial value
// R3: reset sets the global interrupt mask bit in the condition codes
// R4: reset disables peripherals and makes all io pins plain inputs
// R5: eight reset sources; all but debug-forced record a status bit
// R6: entering reset switches the clock generator to self-clocked mode
// R7: reset pin driven low 34 bus cycles, then released
// R8: 38 cycles after release the pin is sampled to find pin cause
// R9: enabled watchdog resets the system when it times out unserviced
// R10: watchdog enabled after any reset; clearing the enable bit stops it
// R11: any write to reset status address restarts watchdog, status unchanged
// R12: system options accept one write after reset, then stay locked
// R13: timeout select chooses between two watchdog lengths in bus cycles
// R14: watchdog held off while in active background debug mode
// R15: events set read-only flags; serviced only if enabled and unmasked
// R16: qualified request is taken only at an instruction boundary
// R17: entry stacks registers, sets mask, fetches vector, prefetches three bytes
// R18: hardware entry uses the same sequence as the software interrupt
// R19: return restores condition codes, accumulator, index low and pc
// R20: index high byte is never stacked or restored
// R21: highest priority pending source is serviced first
// R22: stack pc low first, condition codes last, sp ends one below
// R23: vector high byte at first address, low byte at next
// R24: watchdog counter cleared during any reset
module rwic_ctrl #(
  parameter NUM_IRQ = 8,
  parameter WDOG_LONG = `RWIC_WDOG_LONG,
  parameter WDOG_SHORT = `RWIC_WDOG_SHORT
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire reset_pin_in,
  output reg reset_pin_out,
  output reg reset_pin_oe,
  input wire low_voltage_detect,
  input wire illegal_opcode,
  input wire illegal_address,
  input wire debug_force_reset,
  input wire clock_loss,
  input wire bdm_active,
  output reg sys_reset,
  output reg clk_self_mode,
  output reg periph_reset,
  input wire [NUM_IRQ-1:0] int_event,
  input wire [NUM_IRQ-1:0] int_ack,
  input wire core_boundary,
  input wire core_swi,
  input wire core_rti,
  input wire [15:0] core_pc_in,
  input wire [15:0] core_sp_in,
  input wire [7:0] core_a_in,
  input wire [7:0] core_x_in,
  input wire [7:0] core_ccr_in,
  output reg core_run,
  output reg [15:0] core_pc,
  output reg [15:0] core_sp,
  output reg [7:0] core_a,
  output reg [7:0] core_x,
  output reg [7:0] core_ccr,
  output reg core_load_pc,
  output reg core_load_sp,
  output reg core_load_ccr,
  output reg core_load_ax,
  output reg [7:0] queue_byte,
  output reg queue_valid,
  output reg [15:0] mem_addr,
  output reg mem_re,
  output reg mem_we,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata
);

  localparam ST_DRIVE = 4'h0;
  localparam ST_WAIT = 4'h1;
  localparam ST_HOLD = 4'h2;
  localparam ST_VEC = 4'h3;
  localparam ST_PUSH = 4'h4;
  localparam ST_IVEC = 4'h5;
  localparam ST_PULL = 4'h6;
  localparam ST_FILL = 4'h7;
  localparam ST_RUN = 4'h8;

  // full width first, then cut to the counter widths
  localparam [31:0] DRIVE_M1 = `RWIC_PIN_DRIVE_CYCLES - 1;
  localparam [31:0] SAMPLE_M1 = `RWIC_PIN_SAMPLE_CYCLES - 1;
  localparam [31:0] WD_LONG_M1 = WDOG_LONG - 1;
  localparam [31:0] WD_SHORT_M1 = WDOG_SHORT - 1;
  localparam [6:0] DRIVE_LAST = DRIVE_M1[6:0];
  localparam [6:0] SAMPLE_LAST = SAMPLE_M1[6:0];
  localparam [17:0] WD_LONG_LAST = WD_LONG_M1[17:0];
  localparam [17:0] WD_SHORT_LAST = WD_SHORT_M1[17:0];

  // vector of interrupt source k, highest index nearest the top
  function [15:0] irq_vector;
    input [7:0] k;
    begin
      irq_vector = `RWIC_VEC_IRQ_TOP - {7'h00, NUM_IRQ[7:0] - 8'h01 - k, 1'b0};
    end
  endfunction

  reg [3:0] state;
  reg [6:0] pin_cnt;
  reg [2:0] cnt;
  reg rd_valid;
  reg pin_s1;
  reg pin_s2;
  reg [6:0] rst_status;
  reg [1:0] sys_opt;
  reg opt_locked;
  reg [17:0] wd_cnt;
  reg wd_fire;
  reg [NUM_IRQ-1:0] int_flags;
  reg [NUM_IRQ-1:0] int_enable;
  reg [15:0] sv_pc;
  reg [7:0] sv_x;
  reg [7:0] sv_a;
  reg [7:0] sv_ccr;
  reg [15:0] sp_work;
  reg [15:0] vec_addr;
  reg [15:0] tgt_pc;

  wire in_reset = (state == ST_DRIVE) || (state == ST_WAIT) || (state == ST_HOLD);
  wire apb_setup = psel & ~penable;
  wire apb_write = psel & penable & pready & pwrite;
  wire wd_service = apb_write && (paddr == `RWIC_OFF_RST_STATUS);
  wire [NUM_IRQ-1:0] irq_pending = int_flags & int_enable;
  wire i_mask = core_ccr_in[`RWIC_CCR_I_BIT];
  wire [5:0] src_now = {clock_loss, 1'b0, illegal_address, illegal_opcode, wd_fire, low_voltage_detect};
  wire run_reset = (|src_now) | debug_force_reset | ~pin_s2;
  wire rd_issue = ~mem_re & ~rd_valid;

  // highest index pending source wins
  reg [7:0] top_irq;
  integer i;
  always @* begin
    top_irq = 8'h00;
    for (i = 0; i < NUM_IRQ; i = i + 1) begin
      if (irq_pending[i]) begin
        top_irq = i[7:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end else begin
      pin_s1 <= reset_pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // apb slave, zero wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      if (apb_setup) begin
        case (paddr)
          `RWIC_OFF_RST_STATUS: prdata <= {25'h0000000, rst_status};
          `RWIC_OFF_SYS_OPTIONS: prdata <= {29'h00000000, opt_locked, sys_opt};
          `RWIC_OFF_INT_FLAGS: prdata <= {{(32-NUM_IRQ){1'b0}}, int_flags};
          `RWIC_OFF_INT_ENABLE: prdata <= {{(32-NUM_IRQ){1'b0}}, int_enable};
          `RWIC_OFF_SEQ_STATUS: prdata <= {24'h000000, in_reset, i_mask, 2'h0, state};
          default: begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // system options and interrupt enables
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_opt <= `RWIC_OPT_RESET;
      opt_locked <= 1'b0;
      int_enable <= {NUM_IRQ{1'b0}};
    end else if (in_reset) begin
      // R10: enable back on after reset
      sys_opt <= `RWIC_OPT_RESET;
      opt_locked <= 1'b0;
      // R4: local enables off
      int_enable <= {NUM_IRQ{1'b0}};
    end else if (apb_write) begin
      // R12: write once, then locked
      if (paddr == `RWIC_OFF_SYS_OPTIONS && !opt_locked) begin
        sys_opt <= pwdata[1:0];
        opt_locked <= 1'b1;
      end
      if (paddr == `RWIC_OFF_INT_ENABLE) begin
        int_enable <= pwdata[NUM_IRQ-1:0];
      end
    end
  end

  // R15: sticky flags, set beats ack
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_flags <= {NUM_IRQ{1'b0}};
    end else if (in_reset) begin
      int_flags <= {NUM_IRQ{1'b0}};
    end else begin
      int_flags <= (int_flags & ~int_ack) | int_event;
    end
  end

  // watchdog counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt <= 18'h00000;
      wd_fire <= 1'b0;
    end else begin
      wd_fire <= 1'b0;
      // R24: cleared during reset
      if (in_reset) begin
        wd_cnt <= 18'h00000;
      // R11: any write to status restarts
      end else if (wd_service) begin
        wd_cnt <= 18'h00000;
      // R14: paused in background debug
      end else if (sys_opt[`RWIC_OPT_WDOG_EN] && !bdm_active && !wd_fire) begin
        // R13: length chosen by select
        // R9: timeout raises reset
        if (wd_cnt == (sys_opt[`RWIC_OPT_WDOG_SEL] ? WD_LONG_LAST : WD_SHORT_LAST)) begin
          wd_fire <= 1'b1;
          wd_cnt <= 18'h00000;
        end else begin
          wd_cnt <= wd_cnt + 18'h00001;
        end
      end
    end
  end

  // reset sequencer and core entry and return sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_DRIVE;
      pin_cnt <= 7'h00;
      cnt <= 3'h0;
      rd_valid <= 1'b0;
      rst_status <= `RWIC_RS_POR_VALUE;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b1;
      sys_reset <= 1'b1;
      clk_self_mode <= 1'b1;
      periph_reset <= 1'b1;
      core_run <= 1'b0;
      core_pc <= 16'h0000;
      core_sp <= `RWIC_SP_RESET;
      core_a <= 8'h00;
      core_x <= 8'h00;
      core_ccr <= 8'h00;
      core_load_pc <= 1'b0;
      core_load_sp <= 1'b0;
      core_load_ccr <= 1'b0;
      core_load_ax <= 1'b0;
      queue_byte <= 8'h00;
      queue_valid <= 1'b0;
      mem_addr <= 16'h0000;
      mem_re <= 1'b0;
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
      sv_pc <= 16'h0000;
      sv_x <= 8'h00;
      sv_a <= 8'h00;
      sv_ccr <= 8'h00;
      sp_work <= 16'h0000;
      vec_addr <= 16'h0000;
      tgt_pc <= 16'h0000;
    end else begin
      rd_valid <= mem_re;
      mem_re <= 1'b0;
      mem_we <= 1'b0;
      core_load_pc <= 1'b0;
      core_load_sp <= 1'b0;
      core_load_ccr <= 1'b0;
      core_load_ax <= 1'b0;
      queue_valid <= 1'b0;
      case (state)
        ST_DRIVE: begin
          // R7: pin low for the drive time
          if (pin_cnt == DRIVE_LAST) begin
            pin_cnt <= 7'h00;
            reset_pin_oe <= 1'b0;
            state <= ST_WAIT;
          end else begin
            pin_cnt <= pin_cnt + 7'h01;
          end
        end
        ST_WAIT: begin
          // R8: sample the pin after the wait
          if (pin_cnt == SAMPLE_LAST) begin
            pin_cnt <= 7'h00;
            if (!pin_s2) begin
              rst_status[`RWIC_RS_PIN] <= 1'b1;
              state <= ST_HOLD;
            end else begin
              state <= ST_VEC;
              cnt <= 3'h0;
            end
          end else begin
            pin_cnt <= pin_cnt + 7'h01;
          end
        end
        ST_HOLD: begin
          if (pin_s2) begin
            state <= ST_VEC;
            cnt <= 3'h0;
          end
        end
        ST_VEC: begin
          // R1: reset vector, high byte first
          if (rd_issue) begin
            mem_re <= 1'b1;
            mem_addr <= `RWIC_VEC_RESET + {15'h0000, cnt[0]};
          end else if (rd_valid) begin
            if (cnt == 3'h0) begin
              tgt_pc[15:8] <= mem_rdata;
              cnt <= 3'h1;
            end else begin
              tgt_pc[7:0] <= mem_rdata;
              cnt <= 3'h0;
              state <= ST_FILL;
              sys_reset <= 1'b0;
              // R4: peripherals released once the reset vector is fetched, before the prefetch
              periph_reset <= 1'b0;
              clk_self_mode <= 1'b0;
              // R2: fixed stack pointer
              core_sp <= `RWIC_SP_RESET;
              core_load_sp <= 1'b1;
              // R3: mask set by reset
              core_ccr <= 8'h00 | (8'h01 << `RWIC_CCR_I_BIT);
              core_load_ccr <= 1'b1;
            end
          end
        end
        ST_RUN: begin
          // R16: only at an instruction boundary
          // R15: enabled flag and clear mask required
          if (core_boundary && (core_swi || core_rti || (|irq_pending && !i_mask))) begin
            core_run <= 1'b0;
            cnt <= 3'h0;
            sv_pc <= core_pc_in;
            sv_x <= core_x_in;
            sv_a <= core_a_in;
            sv_ccr <= core_ccr_in;
            sp_work <= core_sp_in;
            if (core_rti) begin
              state <= ST_PULL;
            end else begin
              // R18: hardware and swi share one path
              state <= ST_PUSH;
              // R21: highest priority pending
              vec_addr <= core_swi ? `RWIC_VEC_SWI : irq_vector(top_irq);
            end
          end
        end
        ST_PUSH: begin
          // R22: pc low first, ccr last
          // R20: index high never stacked
          mem_we <= 1'b1;
          mem_addr <= sp_work;
          sp_work <= sp_work - 16'h0001;
          cnt <= cnt + 3'h1;
          case (cnt)
            3'h0: mem_wdata <= sv_pc[7:0];
            3'h1: mem_wdata <= sv_pc[15:8];
            3'h2: mem_wdata <= sv_x;
            3'h3: mem_wdata <= sv_a;
            default: mem_wdata <= sv_ccr;
          endcase
          if (cnt == `RWIC_STACK_BYTES - 3'h1) begin
            cnt <= 3'h0;
            state <= ST_IVEC;
            // R17: mask set on entry
            core_ccr <= sv_ccr | (8'h01 << `RWIC_CCR_I_BIT);
            core_load_ccr <= 1'b1;
            core_sp <= sp_work - 16'h0001;
            core_load_sp <= 1'b1;
          end
        end
        ST_IVEC: begin
          // R23: vector high then low byte
          if (rd_issue) begin
            mem_re <= 1'b1;
            mem_addr <= vec_addr + {15'h0000, cnt[0]};
          end else if (rd_valid) begin
            if (cnt == 3'h0) begin
              tgt_pc[15:8] <= mem_rdata;
              cnt <= 3'h1;
            end else begin
              tgt_pc[7:0] <= mem_rdata;
              cnt <= 3'h0;
              state <= ST_FILL;
            end
          end
        end
        ST_PULL: begin
          // R19: ccr, a, x, pc back in reverse order
          if (rd_issue) begin
            mem_re <= 1'b1;
            mem_addr <= sp_work + 16'h0001;
            sp_work <= sp_work + 16'h0001;
          end else if (rd_valid) begin
            cnt <= cnt + 3'h1;
            case (cnt)
              3'h0: core_ccr <= mem_rdata;
              3'h1: core_a <= mem_rdata;
              3'h2: core_x <= mem_rdata;
              3'h3: tgt_pc[15:8] <= mem_rdata;
              default: tgt_pc[7:0] <= mem_rdata;
            endcase
            if (cnt == `RWIC_STACK_BYTES - 3'h1) begin
              cnt <= 3'h0;
              state <= ST_FILL;
              core_load_ccr <= 1'b1;
              core_load_ax <= 1'b1;
              core_sp <= sp_work;
              core_load_sp <= 1'b1;
            end
          end
        end
        ST_FILL: begin
          // R17: prefetch three bytes at target
          if (rd_issue) begin
            mem_re <= 1'b1;
            mem_addr <= tgt_pc + {13'h0000, cnt};
          end else if (rd_valid) begin
            queue_byte <= mem_rdata;
            queue_valid <= 1'b1;
            cnt <= cnt + 3'h1;
            if (cnt == `RWIC_FILL_BYTES - 3'h1) begin
              cnt <= 3'h0;
              core_pc <= tgt_pc;
              core_load_pc <= 1'b1;
              core_run <= 1'b1;
              state <= ST_RUN;
            end
          end
        end
        default: state <= ST_DRIVE;
      endcase
      // R5: any source outside the drive, wait and hold states restarts the reset sequence
      if (state != ST_DRIVE && !in_reset && run_reset) begin
        state <= ST_DRIVE;
        pin_cnt <= 7'h00;
        cnt <= 3'h0;
        mem_re <= 1'b0;
        mem_we <= 1'b0;
        rd_valid <= 1'b0;
        rst_status <= {clock_loss, ~pin_s2, illegal_address, illegal_opcode, wd_fire, low_voltage_detect, 1'b0};
        reset_pin_oe <= 1'b1;
        sys_reset <= 1'b1;
        // R6: clock to self mode
        clk_self_mode <= 1'b1;
        // R4: peripherals and pins held in reset
        periph_reset <= 1'b1;
        core_run <= 1'b0;
      end
    end
  end

endmodule

// >>> src/rwic_defines.vh
`ifndef RWIC_DEFINES_VH
`define RWIC_DEFINES_VH

// register byte offsets on the apb
`define RWIC_OFF_RST_STATUS 12'h000
`define RWIC_OFF_SYS_OPTIONS 12'h004
`define RWIC_OFF_INT_FLAGS 12'h008
`define RWIC_OFF_INT_ENABLE 12'h00C
`define RWIC_OFF_SEQ_STATUS 12'h010

// reset status bit positions
`define RWIC_RS_POR 0
`define RWIC_RS_LVD 1
`define RWIC_RS_WDOG 2
`define RWIC_RS_ILLOP 3
`define RWIC_RS_ILLADDR 4
`define RWIC_RS_PIN 5
`define RWIC_RS_CLKLOSS 6
`define RWIC_RS_POR_VALUE 7'h01

// system options fields and reset value
`define RWIC_OPT_WDOG_EN 0
`define RWIC_OPT_WDOG_SEL 1
`define RWIC_OPT_RESET 2'h3

// core reset values and vectors
`define RWIC_SP_RESET 16'h00FF
`define RWIC_CCR_I_BIT 3
`define RWIC_VEC_RESET 16'hFFFE
`define RWIC_VEC_SWI 16'hFFFC
`define RWIC_VEC_IRQ_TOP 16'hFFFA

// reset pin timing in bus cycles
`define RWIC_PIN_DRIVE_CYCLES 34
`define RWIC_PIN_SAMPLE_CYCLES 38

// watchdog timeouts in bus cycles
`define RWIC_WDOG_LONG 262144
`define RWIC_WDOG_SHORT 8192

// bytes stacked and bytes prefetched
`define RWIC_STACK_BYTES 3'h5
`define RWIC_FILL_BYTES 3'h3

`endif

// >>> verification/rwic_checker.sv
`timescale 1ns/1ns
module rwic_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire reset_pin_out,
  input wire reset_pin_oe,
  input wire sys_reset,
  input wire clk_self_mode,
  input wire periph_reset,
  input wire core_run,
  input wire core_load_ccr,
  input wire core_load_sp,
  input wire [7:0] core_ccr,
  input wire [15:0] mem_addr,
  input wire mem_re,
  input wire mem_we
);
  reg [7:0] oe_cnt;
  // cycles the pin has been driven
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_cnt <= 8'h00;
    end else begin
      oe_cnt <= reset_pin_oe ? oe_cnt + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_push;
    mem_we [*5];
  endsequence
  sequence s_mask;
    core_load_ccr && core_ccr[3] && core_load_sp;
  endsequence
  AST_PIN_LEN: assert property ($fell(reset_pin_oe) |-> oe_cnt == 8'h22)
    else $error("reset pin drive length wrong");
  AST_PIN_LOW: assert property (reset_pin_oe |-> !reset_pin_out)
    else $error("reset pin driven high");
  AST_RST_STATE: assert property (reset_pin_oe && $past(reset_pin_oe) |->
    sys_reset && clk_self_mode && periph_reset && !core_run)
    else $error("reset state outputs wrong");
  AST_RUN_HELD: assert property (sys_reset |-> !core_run)
    else $error("core runs during reset");
  AST_ENTRY: assert property ($rose(mem_we) |-> s_push ##0 s_mask)
    else $error("interrupt entry sequence wrong");
  AST_STACK_DOWN: assert property ($rose(mem_we) |-> ##4 (mem_addr == $past(mem_addr, 4) - 16'h0004))
    else $error("stack pushes not descending");
  AST_APB_ANS: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_APB_ERR: assert property (psel && penable && pready && (paddr > 12'h010) |-> pslverr)
    else $error("unmapped access not refused");
  AST_MEM_EXCL: assert property (!(mem_re && mem_we))
    else $error("read and write strobes together");
endmodule

// >>> verification/rwic_mem_model.sv
`timescale 1ns/1ns
module rwic_mem_model (
  input wire pclk,
  input wire [15:0] mem_addr,
  input wire mem_re,
  input wire mem_we,
  input wire [7:0] mem_wdata,
  output reg [7:0] mem_rdata
);
  reg [7:0] mem [0:65535];
  integer i;
  initial begin
    mem_rdata = 8'h00;
    for (i = 0; i < 65536; i = i + 1) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
  end
  // data valid one cycle after the strobe, toggling otherwise
  always @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
    mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
  end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg [5:0] src = 6'h00;
  reg bdm = 1'b0;
  reg [7:0] ev = 8'h00;
  reg [7:0] ack = 8'h00;
  reg bnd = 1'b1;
  reg software_interrupt_instr = 1'b0;
  reg return_from_interrupt_instr = 1'b0;
  reg [15:0] sp_in = 16'h0080;
  reg [7:0] ccr_in = 8'h08;
  reg [15:0] set_sp = 16'h0080;
  reg [7:0] set_ccr = 8'h08;
  reg core_wr = 1'b0;
  reg [23:0] q_bytes = 24'h000000;
  reg [15:0] c_pc;
  reg [7:0] c_a, c_x;
  reg [31:0] rd;
  reg err, rs_q = 1'b0, run_q = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, pin_out, pin_oe, sys_reset, core_run, ld_pc, ld_sp, ld_ccr, ld_ax, mem_re, mem_we, q_val;
  wire [15:0] core_pc, core_sp, mem_addr;
  wire [7:0] core_a, core_x, core_ccr, mem_wdata, mem_rdata, q_byte;
  // external pullup unless the bench holds the pin low
  wire pin = pin_oe ? pin_out : !src[5];
  integer n_errors, num_checks, cyc, k, i, n_rst = 0, n_ent = 0, run_cyc = 0, last_run = 0;
  localparam [47:0] ST = 48'h200040100802;
  always #10 pclk = ~pclk;
  rwic_ctrl #(.WDOG_LONG(64), .WDOG_SHORT(16)) u_rwic_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin_in(pin), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
    .low_voltage_detect(src[0]), .illegal_opcode(src[1]), .illegal_address(src[2]), .clock_loss(src[3]),
    .debug_force_reset(src[4]), .bdm_active(bdm), .sys_reset(sys_reset), .clk_self_mode(), .periph_reset(),
    .int_event(ev), .int_ack(ack), .core_boundary(bnd), .core_swi(software_interrupt_instr), .core_rti(return_from_interrupt_instr),
    .core_pc_in(16'h4321), .core_sp_in(sp_in), .core_a_in(8'hA1), .core_x_in(8'hB2), .core_ccr_in(ccr_in),
    .core_run(core_run), .core_pc(core_pc), .core_sp(core_sp), .core_a(core_a), .core_x(core_x),
    .core_ccr(core_ccr), .core_load_pc(ld_pc), .core_load_sp(ld_sp), .core_load_ccr(ld_ccr),
    .core_load_ax(ld_ax), .queue_byte(q_byte), .queue_valid(q_val), .mem_addr(mem_addr), .mem_re(mem_re),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  rwic_mem_model u_mem (.pclk(pclk), .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // core side: registers follow the load pulses
  always @(posedge pclk) begin
    if (ld_pc) c_pc <= core_pc;
    if (ld_sp) sp_in <= core_sp;
    else if (core_wr) sp_in <= set_sp;
    if (ld_ccr) ccr_in <= core_ccr;
    else if (core_wr) ccr_in <= set_ccr;
    if (q_val) q_bytes <= {q_bytes[15:0], q_byte};
    if (ld_ax) c_a <= core_a;
    if (ld_ax) c_x <= core_x;
  end
  always @(negedge pclk) begin
    rs_q <= sys_reset;
    run_q <= core_run;
    run_cyc <= sys_reset ? 0 : run_cyc + 1;
    if (sys_reset && !rs_q) last_run <= run_cyc;
    if (sys_reset && !rs_q) n_rst <= n_rst + 1;
    if (!core_run && run_q && !sys_reset) n_ent <= n_ent + 1;
  end
  function [15:0] vec(input [15:0] a);
    vec = {a[7:0] ^ 8'h5A, (a[7:0] + 8'h01) ^ 8'h5A};
  endfunction
  // three prefetch bytes the memory model holds at a
  function [23:0] fill3(input [15:0] a);
    fill3 = {a[7:0] ^ 8'h5A, (a[7:0] + 8'h01) ^ 8'h5A, (a[7:0] + 8'h02) ^ 8'h5A};
  endfunction
  task end_sim;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  task hang;
    begin
      n_errors = n_errors + 1;
      end_sim;
    end
  endtask
  task chk(input [63:0] g, input [63:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // core side: overwrite live sp and ccr for one edge
  task core_set(input [15:0] s, input [7:0] c);
    begin
      set_sp <= s;
      set_ccr <= c;
      core_wr <= 1'b1;
      @(posedge pclk);
      core_wr <= 1'b0;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        n = n + 1;
        if (n > 50) hang;
        @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wt(input s, input v);
    begin
      cyc = 0;
      @(negedge pclk);
      while ((s ? sys_reset : core_run) !== v) begin
        cyc = cyc + 1;
        if (cyc > 3000) hang;
        @(negedge pclk);
      end
      @(posedge pclk);
      @(posedge pclk);
    end
  endtask
  task entry(input [15:0] v, input [7:0] cc);
    begin
      wt(0, 1'b0);
      wt(0, 1'b1);
      chk(c_pc, vec(v));
      chk({u_mem.mem[16'h0080], u_mem.mem[16'h007F], u_mem.mem[16'h007E], u_mem.mem[16'h007D],
        u_mem.mem[16'h007C], sp_in, ccr_in}, {32'h2143B2A1, cc, 16'h007B, cc | 8'h08});
      chk(q_bytes, fill3(vec(v)));
      ack <= 8'hFF;
      @(posedge pclk);
      ack <= 8'h00;
    end
  endtask
  initial begin
    n_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge pclk);
    chk({sys_reset, core_run, pin_oe}, 3'h5);
    presetn <= 1'b1;
    wt(0, 1'b1);
    chk({c_pc, sp_in, ccr_in}, {vec(16'hFFFE), 24'h00FF08});
    apb(0, 12'h000, 0);
    chk(rd, 32'h01);
    apb(0, 12'h004, 0);
    chk(rd, 32'h03);
    apb(1, 12'h020, 32'h5);
    chk(err, 1'b1);
    wt(1, 1'b1);
    chk(last_run > 40 && last_run < 70, 1'b1);
    wt(0, 1'b1);
    k = n_rst;
    repeat (4) begin
      repeat (40) @(posedge pclk);
      apb(1, 12'h000, 32'hFF);
    end
    apb(0, 12'h000, 0);
    chk({rd, n_rst - k}, {32'h04, 32'h0});
    bdm <= 1'b1;
    repeat (150) @(posedge pclk);
    bdm <= 1'b0;
    apb(1, 12'h000, 0);
    chk(n_rst - k, 0);
    apb(1, 12'h004, 32'h1);
    wt(1, 1'b1);
    chk(cyc >= 8 && cyc <= 18, 1'b1);
    wt(0, 1'b1);
    apb(1, 12'h004, 0);
    apb(1, 12'h004, 32'h3);
    apb(0, 12'h004, 0);
    chk(rd, 32'h04);
    k = n_rst;
    repeat (150) @(posedge pclk);
    chk(n_rst - k, 0);
    for (i = 0; i < 6; i = i + 1) begin
      src <= 6'h01 << i;
      repeat (i == 5 ? 200 : 1) @(posedge pclk);
      src <= 6'h00;
      wt(1, 1'b1);
      wt(0, 1'b1);
      apb(0, 12'h000, 0);
      chk(rd, ST[i*8 +: 8]);
      apb(1, 12'h004, 0);
    end
    core_set(16'h0080, 8'h08);
    apb(1, 12'h00C, 32'h04);
    ev <= 8'h04;
    @(posedge pclk);
    ev <= 8'h00;
    apb(0, 12'h008, 0);
    chk(rd, 32'h04);
    k = n_ent;
    repeat (30) @(posedge pclk);
    apb(1, 12'h00C, 0);
    core_set(16'h0080, 8'h00);
    repeat (30) @(posedge pclk);
    bnd <= 1'b0;
    apb(1, 12'h00C, 32'h04);
    repeat (30) @(posedge pclk);
    chk(n_ent - k, 0);
    bnd <= 1'b1;
    entry(16'hFFF0, 8'h00);
    return_from_interrupt_instr <= 1'b1;
    @(posedge pclk);
    return_from_interrupt_instr <= 1'b0;
    wt(0, 1'b0);
    wt(0, 1'b1);
    chk({c_pc, ccr_in, c_a, c_x, sp_in}, 56'h4321_00_A1_B2_0080);
    core_set(16'h0080, 8'h08);
    software_interrupt_instr <= 1'b1;
    @(posedge pclk);
    software_interrupt_instr <= 1'b0;
    entry(16'hFFFC, 8'h08);
    core_set(16'h0080, 8'h08);
    apb(1, 12'h00C, 32'h22);
    ev <= 8'h22;
    @(posedge pclk);
    ev <= 8'h00;
    core_set(16'h0080, 8'h00);
    entry(16'hFFF6, 8'h00);
    end_sim;
  end
endmodule
bind rwic_ctrl rwic_checker u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .reset_pin_out,
  .reset_pin_oe, .sys_reset, .clk_self_mode, .periph_reset, .core_run, .core_load_ccr, .core_load_sp, .core_ccr,
  .mem_addr, .mem_re, .mem_we);
